/* File: bag_blit_addr.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bag_blit_addr (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  output var  bag_pkg::bag_mem_req_s mem_req,
  input  wire bag_pkg::bag_mem_rsp_s mem_rsp,
  output var  logic                 busy
);
  import bag_pkg::*;

  // ==========================================================================
  // Register storage
  logic [31:0]            src_start_q;
  logic [31:0]            dst_start_q;
  logic [BAG_PIX_W-1:0]   src_pix_q;
  logic [31:0]            dst_pix_q;
  logic [BAG_WORDS_W-1:0] src_words_q;
  logic [BAG_WORDS_W-1:0] src_stride_q;
  logic [BAG_WORDS_W-1:0] dst_words_q;
  logic [BAG_LINES_W-1:0] dst_lines_q;
  logic [BAG_WORDS_W-1:0] dst_stride_q;
  logic [31:0]            ctrl_q;
  logic                   start_q;
  logic                   done_q;
  logic                   fault_q;

  // ==========================================================================
  // Walker state
  bag_state_e             state_q;
  bag_walk_s              src_q;
  bag_walk_s              dst_q;
  logic [BAG_LINES_W-1:0] line_q;
  logic [BAG_ITER_W-1:0]  iter_q;
  logic                   line_mode_q;
  bag_mem_req_s           mem_q;

  // APB handshake terms and walker next values
  logic                   acc_first;
  logic                   acc_done;
  logic                   wr_done;
  logic [BAG_ITER_W-1:0]  iter_total;
  bag_walk_s              src_next;
  bag_walk_s              dst_next;

  // ==========================================================================
  // Helpers
  // Step one word along a line; at the end of the line jump by the stride
  function automatic bag_walk_s bag_step(input bag_walk_s pos,
                                         input logic [BAG_WORDS_W-1:0] last,
                                         input logic [BAG_WORDS_W-1:0] stride);
    bag_walk_s nxt;
    nxt = pos;
    if (pos.cnt == last) begin
      nxt.cnt  = '0;
      nxt.line = pos.line + {18'h0, stride};
      nxt.ptr  = pos.line + {18'h0, stride};
    end else begin
      nxt.cnt  = pos.cnt + 12'h001;
      nxt.ptr  = pos.ptr + 30'h0000_0001;
    end
    return nxt;
  endfunction : bag_step

  // Fresh walk position from a start register, low two bits dropped
  function automatic bag_walk_s bag_origin(input logic [31:0] start);
    bag_walk_s pos;
    pos.line = start[31:2];
    pos.ptr  = start[31:2];
    pos.cnt  = '0;
    return pos;
  endfunction : bag_origin

  // ==========================================================================
  // APB handshake: one wait state, so every access takes two access cycles
  assign acc_first = psel & penable & ~pready;
  assign acc_done  = psel & penable & pready;
  assign wr_done   = acc_done & pwrite;

  // Destination walk and source walk advance with the same stepping rule
  assign src_next   = bag_step(src_q, src_words_q, src_stride_q);
  assign dst_next   = bag_step(dst_q, dst_words_q, dst_stride_q);
  // Plain product of the raw fields; a zero field gives zero iterations
  assign iter_total = BAG_ITER_W'(dst_words_q) * BAG_ITER_W'(dst_lines_q);

  // Ready rises on the second access cycle and completes on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_first;
    end
  end

  // Read mux and slave error, loaded one cycle before completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc_first) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      // Byte lanes are not decoded; only whole-word access is meaningful
      unique case (paddr)
        BAG_SRC_PIX_ADDR:    prdata <= {27'h0, src_pix_q};
        BAG_DST_PIX_ADDR:    prdata <= dst_pix_q;
        BAG_SRC_START_ADDR:  prdata <= src_start_q;
        BAG_DST_START_ADDR:  prdata <= dst_start_q;
        BAG_SRC_WORDS_ADDR:  prdata <= {20'h0, src_words_q};
        BAG_SRC_STRIDE_ADDR: prdata <= {20'h0, src_stride_q};
        BAG_DST_WORDS_ADDR:  prdata <= {20'h0, dst_words_q};
        BAG_DST_LINES_ADDR:  prdata <= {21'h0, dst_lines_q};
        BAG_DST_STRIDE_ADDR: prdata <= {20'h0, dst_stride_q};
        BAG_CTRL_ADDR:       prdata <= ctrl_q;
        BAG_SRC_PTR_ADDR:    prdata <= {src_q.ptr, 2'b00};
        BAG_DST_PTR_ADDR:    prdata <= {dst_q.ptr, 2'b00};
        BAG_ITER_ADDR:       prdata <= {9'h0, iter_q};
        default:             pslverr <= 1'b1;
      endcase
    end else begin
      // Error stands only beside its own ready pulse
      pslverr <= 1'b0;
    end
  end

  // ==========================================================================
  // Geometry and address registers; writes take effect at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_start_q  <= BAG_REG_RESET;
      dst_start_q  <= BAG_REG_RESET;
      src_pix_q    <= '0;
      dst_pix_q    <= BAG_REG_RESET;
      src_words_q  <= '0;
      src_stride_q <= '0;
      dst_words_q  <= '0;
      dst_lines_q  <= '0;
      dst_stride_q <= '0;
    end else if (wr_done) begin
      unique case (paddr)
        BAG_SRC_START_ADDR:  src_start_q  <= pwdata;
        BAG_DST_START_ADDR:  dst_start_q  <= pwdata;
        BAG_SRC_PIX_ADDR:    src_pix_q    <= pwdata[BAG_PIX_W-1:0];
        BAG_DST_PIX_ADDR:    dst_pix_q    <= pwdata & BAG_DST_PIX_MASK;
        BAG_SRC_WORDS_ADDR:  src_words_q  <= pwdata[BAG_WORDS_W-1:0];
        BAG_SRC_STRIDE_ADDR: src_stride_q <= pwdata[BAG_WORDS_W-1:0];
        BAG_DST_WORDS_ADDR:  dst_words_q  <= pwdata[BAG_WORDS_W-1:0];
        BAG_DST_LINES_ADDR:  dst_lines_q  <= pwdata[BAG_LINES_W-1:0];
        BAG_DST_STRIDE_ADDR: dst_stride_q <= pwdata[BAG_WORDS_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Control register: start bit, error flag and stored mode bits
  // Hardware set of the error flag wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= BAG_REG_RESET;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_done && paddr == BAG_CTRL_ADDR) begin
        ctrl_q  <= pwdata & BAG_CTRL_MASK;
        start_q <= pwdata[BAG_CTRL_START_BIT];
      end else if (done_q) begin
        ctrl_q[BAG_CTRL_START_BIT] <= 1'b0;
      end
      if (fault_q) begin
        ctrl_q[BAG_CTRL_ERROR_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Walker: read one source word, write one destination word, repeat; line draw only writes
  // Clearing the start bit drops a request mid-flight; memory must tolerate it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= BAG_IDLE;
      src_q       <= '0;
      dst_q       <= '0;
      line_q      <= '0;
      iter_q      <= '0;
      line_mode_q <= 1'b0;
      mem_q       <= '0;
      done_q      <= 1'b0;
      fault_q     <= 1'b0;
    end else begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      unique case (state_q)
        BAG_IDLE: begin
          mem_q <= '0;
          if (start_q) begin
            src_q       <= bag_origin(src_start_q);
            dst_q       <= bag_origin(dst_start_q);
            line_q      <= '0;
            iter_q      <= iter_total;
            line_mode_q <= ctrl_q[BAG_CTRL_LINE_BIT];
            if (ctrl_q[BAG_CTRL_LINE_BIT]) begin
              if (iter_total == '0) begin
                done_q <= 1'b1;
              end else begin
                state_q     <= BAG_WRITE;
                mem_q.req   <= 1'b1;
                mem_q.we    <= 1'b1;
                mem_q.addr  <= {dst_start_q[31:2], 2'b00};
                mem_q.wdata <= 32'h0000_0000;
                mem_q.pix   <= dst_pix_q[BAG_SPEL_LSB +: BAG_PIX_W];
              end
            end else begin
              state_q     <= BAG_READ;
              mem_q.req   <= 1'b1;
              mem_q.we    <= 1'b0;
              mem_q.addr  <= {src_start_q[31:2], 2'b00};
              mem_q.wdata <= 32'h0000_0000;
              mem_q.pix   <= src_pix_q;
            end
          end
        end
        BAG_READ: begin
          if (mem_rsp.ack && mem_rsp.err) begin
            state_q <= BAG_IDLE;
            mem_q   <= '0;
            fault_q <= 1'b1;
            done_q  <= 1'b1;
          end else if (mem_rsp.ack) begin
            // A read answered without error always gets its write request, even when an abort is pending
            src_q       <= src_next;
            state_q     <= BAG_WRITE;
            mem_q.we    <= 1'b1;
            mem_q.addr  <= {dst_q.ptr, 2'b00};
            mem_q.wdata <= mem_rsp.rdata;
            mem_q.pix   <= (dst_q.cnt == '0) ? dst_pix_q[BAG_SPEL_LSB +: BAG_PIX_W] : '0;
          end else if (!ctrl_q[BAG_CTRL_START_BIT]) begin
            state_q <= BAG_IDLE;
            mem_q   <= '0;
            done_q  <= 1'b1;
          end
        end
        BAG_WRITE: begin
          if (mem_rsp.ack && mem_rsp.err) begin
            state_q <= BAG_IDLE;
            mem_q   <= '0;
            fault_q <= 1'b1;
            done_q  <= 1'b1;
          end else if (!mem_rsp.ack && !ctrl_q[BAG_CTRL_START_BIT]) begin
            state_q <= BAG_IDLE;
            mem_q   <= '0;
            done_q  <= 1'b1;
          end else if (mem_rsp.ack) begin
            dst_q <= dst_next;
            if (dst_q.cnt == dst_words_q) begin
              line_q <= line_q + 11'h001;
            end
            if (line_mode_q) begin
              iter_q <= iter_q - 23'h00_0001;
            end
            if (!ctrl_q[BAG_CTRL_START_BIT]) begin
              // Abort lands after the answered write, so no answered write is lost
              state_q <= BAG_IDLE;
              mem_q   <= '0;
              done_q  <= 1'b1;
            end else if (line_mode_q) begin
              // Line draw: a fixed number of destination steps
              if (iter_q == 23'h00_0001) begin
                state_q <= BAG_IDLE;
                mem_q   <= '0;
                done_q  <= 1'b1;
              end else begin
                mem_q.addr <= {dst_next.ptr, 2'b00};
                mem_q.pix  <= '0;
              end
            end else if (dst_q.cnt == dst_words_q && line_q == dst_lines_q) begin
              state_q <= BAG_IDLE;
              mem_q   <= '0;
              done_q  <= 1'b1;
            end else begin
              state_q     <= BAG_READ;
              mem_q.we    <= 1'b0;
              mem_q.wdata <= 32'h0000_0000;
              mem_q.addr  <= {src_q.ptr, 2'b00};
              mem_q.pix   <= (src_q.cnt == '0) ? src_pix_q : '0;
            end
          end
        end
        default: begin
          state_q <= BAG_IDLE;
          mem_q   <= '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign mem_req = mem_q;

  // Busy is registered from a non-idle walker state or the start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_q != BAG_IDLE) | start_q;
    end
  end

endmodule : bag_blit_addr

`default_nettype wire

/* File: bag_blit_addr_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module bag_blit_addr_chk
  import bag_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire bag_mem_req_s mem_req,
  input wire bag_mem_rsp_s mem_rsp,
  input wire logic         busy
);
  // ==========
  // Register port handshake
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // ==========
  // Frame memory side
  // A request may only vanish through an abort, never change in place
  a_req_hold: assert property (mem_req.req && !mem_rsp.ack
                               |=> !mem_req.req || $stable(mem_req))
    else $error("memory request changed before ack");
  a_word_align: assert property (mem_req.req |-> mem_req.addr[1:0] == 2'b00)
    else $error("memory address not word aligned");
  a_req_busy: assert property (mem_req.req |-> busy)
    else $error("memory request while not busy");
  a_copy_pair: assert property (mem_req.req && !mem_req.we && mem_rsp.ack && !mem_rsp.err
    |=> mem_req.req && mem_req.we && mem_req.wdata == $past(mem_rsp.rdata))
    else $error("read word not written next");
  a_err_stop: assert property (mem_req.req && mem_rsp.ack && mem_rsp.err
                               |=> !mem_req.req [*2])
    else $error("walk continued after bus error");
endmodule : bag_blit_addr_chk

bind bag_blit_addr bag_blit_addr_chk bag_blit_addr_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy));

`default_nettype wire

/* File: bag_blit_addr_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module bag_blit_addr_tb;
  import bag_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic         err_on, last_err;
  logic [1:0]   dly;
  logic [31:0]  paddr, pwdata, prdata;
  bag_mem_req_s mem_req;
  bag_mem_rsp_s mem_rsp;
  int           n_fail, tests_run;
  logic         wq[$];
  logic [31:0]  aq[$], dq[$];
  logic [4:0]   pq[$];
  logic [31:0]  ra[7] = '{BAG_SRC_START_ADDR, BAG_DST_START_ADDR, BAG_SRC_WORDS_ADDR,
    BAG_SRC_STRIDE_ADDR, BAG_DST_WORDS_ADDR, BAG_DST_LINES_ADDR, BAG_DST_STRIDE_ADDR};
  logic [31:0]  rm[7] = '{32'hffff_ffff, 32'hffff_ffff, 32'hfff, 32'hfff, 32'hfff,
    32'h7ff, 32'hfff};

  bag_blit_addr bag_blit_addr_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy));
  bag_mem_model bag_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .dly(dly), .err_on(err_on), .mem_rsp(mem_rsp));

  // ==========
  // Clock and completed memory transfers
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mem_req.req === 1'b1 && mem_rsp.ack === 1'b1) begin
      wq.push_back(mem_req.we);
      aq.push_back(mem_req.addr);
      dq.push_back(mem_req.wdata);
      pq.push_back(mem_req.pix);
    end
  end

  // ==========
  // Checking, bus tasks and expectations
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One idle edge before setup keeps release and next setup apart
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin n_fail++; give_verdict(); end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wait_done;
    logic [31:0] q;
    int n;
    n = 0;
    do begin rd(BAG_CTRL_ADDR, q); n++; end while (q[0] !== 1'b0 && n < 300);
    if (n >= 300) begin n_fail++; give_verdict(); end
  endtask : wait_done

  task automatic go(input logic [31:0] v[7], input logic [31:0] ctl);
    foreach (v[i]) wr(ra[i], v[i]);
    wq.delete(); aq.delete(); dq.delete(); pq.delete();
    wr(BAG_CTRL_ADDR, ctl);
    if (ctl != 32'h0) wait_done();
  endtask : go

  // Word address of word k on line l, walking forward from the start word
  function automatic logic [31:0] exp_addr(logic [31:0] b, s, int j, int w);
    return {b[31:2] + 30'((j / (w + 1)) * s) + 30'(j % (w + 1)), 2'b00};
  endfunction : exp_addr

  // Pixel offset rides only on the first word of each line, zero elsewhere
  function automatic logic [31:0] exp_pix(logic [31:0] s, d, int j, int w);
    if ((j / 2) % (w + 1) != 0) return 32'h0;
    return (j % 2) ? {27'h0, d[4:0]} : {27'h0, s[4:0]};
  endfunction : exp_pix

  // ==========
  // Main sequence
  initial begin
    logic [31:0] q, sp, dp, v[7];
    int w, h;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; dly = 2'h0; err_on = 1'b0;
    n_fail = 0; tests_run = 0;
    void'($urandom(64739));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], q);
      chk("reset", 32'h0, q);
      v[i] = $urandom;
      wr(ra[i], v[i]);
      rd(ra[i], q);
      chk("readback", v[i] & rm[i], q);
    end
    rd(32'h8004_0100, q);
    chk("unmapped", 32'h1, {31'h0, last_err});
    sp = $urandom;
    dp = $urandom;
    wr(BAG_SRC_PIX_ADDR, sp);
    wr(BAG_DST_PIX_ADDR, dp);
    rd(BAG_SRC_PIX_ADDR, q);
    chk("source pixel", sp & BAG_SRC_PIX_MASK, q);
    rd(BAG_DST_PIX_ADDR, q);
    chk("dest pixel", dp & BAG_DST_PIX_MASK, q);
    $display("test registers done");
    // Single-word lines and full 4095 strides among random shapes
    for (int t = 0; t < 6; t++) begin
      w = (t == 0) ? 0 : $urandom % 4;
      h = $urandom % 3;
      v = '{$urandom, $urandom, w, $urandom % 16, w, h, $urandom % 16};
      if (t == 1) begin v[3] = 32'hfff; v[6] = 32'hfff; end
      dly <= 2'($urandom);
      go(v, 32'h1);
      chk("count", 2 * (w + 1) * (h + 1), aq.size());
      foreach (aq[i]) begin
        chk("we", i % 2, wq[i]);
        chk("addr", exp_addr(v[i % 2], v[3 + 3 * (i % 2)], i / 2, w), aq[i]);
        chk("pix", exp_pix(sp, dp, i, w), pq[i]);
      end
    end
    $display("test blit done");
    // Line draw over widths 0 to 3; zero width must give no access at all
    for (int t = 0; t < 4; t++) begin
      v[2] = t; v[4] = t; v[5] = $urandom % 4 + 1;
      go(v, 32'h11);
      chk("iters", t * v[5], aq.size());
      foreach (dq[i]) chk("line data", 32'h0, dq[i]);
      foreach (wq[i]) chk("line we", 32'h1, wq[i]);
      foreach (aq[i]) chk("line addr", exp_addr(v[1], v[6], i, t), aq[i]);
    end
    $display("test line done");
    err_on <= 1'b1;
    go(v, 32'h1);
    rd(BAG_CTRL_ADDR, q);
    chk("error", 32'h1_0000, q & 32'h1_0001);
    err_on <= 1'b0;
    v[2] = 3; v[4] = 3; v[5] = 3;
    dly <= 2'h3;
    go(v, 32'h1 );
    go(v, 32'h0);
    wr(BAG_CTRL_ADDR, 32'h1);
    wr(BAG_CTRL_ADDR, 32'h0);
    wait_done();
    chk("abort", 32'h1, {31'h0, aq.size() < 32});
    chk("busy", 32'h0, {31'h0, busy});
    rd(BAG_CTRL_ADDR, q);
    chk("ctrl", 32'h0, q);
    $display("test error and abort done");
    give_verdict();
  end
endmodule : bag_blit_addr_tb

`default_nettype wire

/* File: bag_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bag_mem_model
  import bag_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire bag_mem_req_s mem_req,
  input  wire logic [1:0]   dly,
  input  wire logic         err_on,
  output var  bag_mem_rsp_s mem_rsp
);
  logic [1:0]  wait_q;
  logic [31:0] pat_q;

  // ==========
  // Wait states and idle noise on read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
      pat_q  <= 32'h0;
    end else begin
      pat_q  <= pat_q + 32'h9e37_79b9;
      wait_q <= (mem_rsp.ack || !mem_req.req) ? 2'h0 : wait_q + 2'h1;
    end
  end

  // Ack follows the live request so an aborted request is never answered
  always_comb begin
    mem_rsp.ack   = mem_req.req && (wait_q >= dly);
    mem_rsp.err   = mem_rsp.ack && err_on;
    mem_rsp.rdata = mem_rsp.ack ? (mem_req.addr ^ 32'ha5c3_0f69) : pat_q;
  end
endmodule : bag_mem_model

`default_nettype wire

/* File: bag_pkg.sv */
// Function
// - Source word address is start register bits 31:2, joined with source pixel offset.
// - Destination word address is start register bits 31:2, joined with destination pixel offset.
// - Low two bits of both start registers are unused but read back as written.
// - Source width field is words per source line minus one, up to 4095.
// - Destination width field is words per destination line minus one, up to 4095.
// - Source line address advances by source stride words when a source line ends.
// - Destination height field is the line count of the block minus one.
// - Line-draw iterations equal destination width value times destination height value.
// - Destination line address advances by destination stride words when a line ends.
// - Start bit written one starts, zero terminates; reads one while busy.
`default_nettype none

package bag_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] BAG_SRC_PIX_ADDR     = 32'h8004_0000;
  localparam logic [31:0] BAG_DST_PIX_ADDR     = 32'h8004_0004;
  localparam logic [31:0] BAG_SRC_START_ADDR   = 32'h8004_0008;
  localparam logic [31:0] BAG_DST_START_ADDR   = 32'h8004_000c;
  localparam logic [31:0] BAG_SRC_WORDS_ADDR   = 32'h8004_0010;
  localparam logic [31:0] BAG_SRC_STRIDE_ADDR  = 32'h8004_0014;
  localparam logic [31:0] BAG_DST_WORDS_ADDR   = 32'h8004_0018;
  localparam logic [31:0] BAG_DST_LINES_ADDR   = 32'h8004_001c;
  localparam logic [31:0] BAG_DST_STRIDE_ADDR  = 32'h8004_0020;
  localparam logic [31:0] BAG_CTRL_ADDR        = 32'h8004_0024;
  localparam logic [31:0] BAG_SRC_PTR_ADDR     = 32'h8004_0040;
  localparam logic [31:0] BAG_DST_PTR_ADDR     = 32'h8004_0044;
  localparam logic [31:0] BAG_ITER_ADDR        = 32'h8004_0048;

  // ==========================================================================
  // Field layouts and reset values
  localparam logic [31:0] BAG_SRC_PIX_MASK     = 32'h0000_001f;
  localparam logic [31:0] BAG_DST_PIX_MASK     = 32'h001f_001f;
  localparam logic [31:0] BAG_CTRL_MASK        = 32'h001f_ffff;
  localparam logic [31:0] BAG_REG_RESET        = 32'h0000_0000;
  localparam int          BAG_WORDS_W          = 12;
  localparam int          BAG_LINES_W          = 11;
  localparam int          BAG_PIX_W            = 5;
  localparam int          BAG_ITER_W           = BAG_WORDS_W + BAG_LINES_W;
  localparam int          BAG_SPEL_LSB         = 0;
  localparam int          BAG_CTRL_START_BIT   = 0;
  localparam int          BAG_CTRL_LINE_BIT    = 4;
  localparam int          BAG_CTRL_ERROR_BIT   = 16;

  // ==========================================================================
  // Walker states and carriers
  typedef enum logic [1:0] {
    BAG_IDLE,
    BAG_READ,
    BAG_WRITE
  } bag_state_e;

  // One request toward frame memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [4:0]  pix;
  } bag_mem_req_s;

  // Answer from frame memory
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } bag_mem_rsp_s;

  // Position of one side of the walk
  typedef struct packed {
    logic [29:0] line;
    logic [29:0] ptr;
    logic [11:0] cnt;
  } bag_walk_s;

endpackage : bag_pkg

`default_nettype wire
